// File: hdl/itoc_pkg.sv
// Package with modes, curve constants and fixed-point scales of the overcurrent element.
package itoc_pkg;

  // ==========================================================================
  // Operation modes and the sequencer
  // ==========================================================================
  typedef enum logic [3:0] {
    ITOC_OFF        = 4'h0,
    ITOC_DEFINITE   = 4'h1,
    ITOC_IEC_INV    = 4'h2,
    ITOC_IEC_VINV   = 4'h3,
    ITOC_IEC_EINV   = 4'h4,
    ITOC_IEC_LINV   = 4'h5,
    ITOC_ANSI_INV   = 4'h6,
    ITOC_ANSI_MINV  = 4'h7,
    ITOC_ANSI_VINV  = 4'h8,
    ITOC_ANSI_EINV  = 4'h9,
    ITOC_ANSI_LINV  = 4'ha,
    ITOC_ANSI_LVINV = 4'hb,
    ITOC_ANSI_LEINV = 4'hc
  } itoc_mode_t;

  typedef enum logic [4:0] {
    ITOC_ST_IDLE   = 5'h01,
    ITOC_ST_RATIO  = 5'h02,
    ITOC_ST_CURVE  = 5'h04,
    ITOC_ST_TIME   = 5'h08,
    ITOC_ST_UPDATE = 5'h10
  } itoc_state_t;

  typedef enum logic [1:0] {
    ITOC_A002 = 2'h0,
    ITOC_A1   = 2'h1,
    ITOC_A2   = 2'h2
  } itoc_alpha_t;

  // Curve constants in microseconds.
  typedef struct packed {
    logic [26:0] k_us;
    logic [19:0] c_us;
    logic [24:0] kr_us;
    itoc_alpha_t alpha;
    logic        ansi;
  } itoc_curve_t;

  // Per-phase fundamental RMS values, percent of nominal.
  typedef struct packed {
    logic [2:0][15:0] rms;
  } itoc_meas_t;

  // ==========================================================================
  // Fixed-point scales
  // ==========================================================================
  localparam logic [23:0] ITOC_Q_ONE      = 24'h010000; // Ratio 1.0 in Q16.
  localparam logic [23:0] ITOC_RATIO_LIM  = 24'h140000; // Limit ratio 20.
  localparam int          ITOC_FRAC       = 16;
  localparam logic [17:0] ITOC_Y_COEF     = 18'h38c85; // 0.02*ln2 in Q24.
  localparam int          ITOC_Y_SHIFT    = 24;
  localparam logic [15:0] ITOC_LOG_CORR   = 16'h570a; // 0.34 in Q16.
  localparam int          ITOC_SQ_SHIFT   = 17;      // y*y/2 in Q16.
  localparam int          ITOC_TMS_SCALE  = 100;     // Multiplier in 0.01.
  localparam int          ITOC_MS_TO_UNIT = 100000;  // 1 ms in 0.01 us.
  localparam int          ITOC_DIV_STEPS  = 48;
  localparam logic [35:0] ITOC_Q_SAT      = 36'hfffffffff;

  // Eleven curves: k, c, reset constant, alpha, ANSI flag.
  function automatic itoc_curve_t itoc_curve(input logic [3:0] idx);
    case (idx)
      4'h0: itoc_curve = '{27'h222e0, 20'h0, 25'h0, ITOC_A002, 1'b0};
      4'h1: itoc_curve = '{27'hcdfe60, 20'h0, 25'h0, ITOC_A1, 1'b0};
      4'h2: itoc_curve = '{27'h4c4b400, 20'h0, 25'h0, ITOC_A2, 1'b0};
      4'h3: itoc_curve = '{27'h7270e00, 20'h0, 25'h0, ITOC_A1, 1'b0};
      4'h4: itoc_curve = '{27'h2198, 20'h4844, 25'h704e0, ITOC_A002, 1'b1};
      4'h5: itoc_curve = '{27'hc92c, 20'h1bd50, 25'h4a0150, ITOC_A002, 1'b1};
      4'h6: itoc_curve = '{27'h12b3990, 20'h77df8, 25'h1499700, ITOC_A2, 1'b1};
      4'h7: itoc_curve = '{27'h1ae4c40, 20'h1db64, 25'h1bc07e0, ITOC_A2, 1'b1};
      4'h8: itoc_curve = '{27'h14ff0, 20'h2d2a8, 25'h4630c0, ITOC_A002, 1'b1};
      4'h9: itoc_curve = '{27'h1b3a370, 20'hadd40, 25'hcd6220, ITOC_A2, 1'b1};
      4'ha: itoc_curve = '{27'h3d1a170, 20'h3d090, 25'h1c9c380, ITOC_A2, 1'b1};
      default: itoc_curve = '{27'h0, 20'h0, 25'h0, ITOC_A1, 1'b0};
    endcase
  endfunction : itoc_curve

endpackage : itoc_pkg

// File: hdl/itoc_overcurrent.sv
// Three-phase inverse time overcurrent element with start and trip flags.
//
// Behaviour
// - Definite mode trips after fixed set delay.
// - Inverse time is TMS*(k/(r^alpha-1)+c).
// - Eleven curves with constants k, c, alpha.
// - Curve effective up to twenty times start.
// - Above limit, evaluate curve at limit.
// - Curve operate time at least the minimum delay; definite mode ignores it.
// - Operation guaranteed above 1.1 times start.
// - IEC curves reset after fixed reset delay.
// - ANSI reset time is TMS*kr/(1-r^2).
// - ANSI reset constants with exponent two.
// - Characteristics stage feeds combining decision stage.
// - Mode selects off, definite or curve.
// - Per-phase flags plus general start, trip.
`timescale 1ns/100ps
`default_nettype none

module itoc_overcurrent
  import itoc_pkg::*;
#(
  parameter int SAMPLE_US = 1000 // Spacing of sample_valid pulses.
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        sample_valid,
  input  wire itoc_meas_t  phase_fundamental_rms,
  input  wire itoc_mode_t  operation_mode,
  input  wire logic [15:0] start_current_setting,
  input  wire logic [10:0] time_multiplier,
  input  wire logic [15:0] min_delay_ms,
  input  wire logic [15:0] definite_delay_ms,
  input  wire logic [15:0] reset_delay_ms,
  input  wire logic        block,
  output logic      [2:0]  phase_start,
  output logic      [2:0]  phase_trip,
  output logic             general_start,
  output logic             general_trip
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (SAMPLE_US < 1 || SAMPLE_US > 100000) begin : g_chk
    $error("SAMPLE_US out of range");
  end

  localparam logic [47:0] SAMPLE_UNITS = 48'(SAMPLE_US * ITOC_TMS_SCALE);
  localparam logic [5:0]  DIV_N        = 6'(ITOC_DIV_STEPS);

  typedef struct packed {
    itoc_state_t      fsm;
    logic [1:0]       phase;
    logic [5:0]       cnt;
    logic [32:0]      rem;
    logic [47:0]      quo;
    logic [31:0]      dvs;
    logic             above;
    itoc_meas_t       meas;
    logic [2:0][47:0] elapsed;
    logic [2:0][47:0] rst_el;
    logic [2:0]       start;
    logic [2:0]       trip;
    logic             gstart;
    logic             gtrip;
  } itoc_regs_t;

  itoc_regs_t s_reg;
  itoc_regs_t s_next;

  // Log2 of a Q16 ratio in [1,32) with a parabolic mantissa correction.
  function automatic logic [23:0] itoc_log2(input logic [23:0] r);
    logic [2:0]  e;
    logic [15:0] m;
    logic [31:0] mm;
    logic [31:0] corr;
    e = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (r[ITOC_FRAC + i]) begin
        e = 3'(i);
      end
    end
    m    = 16'(r >> e);
    mm   = 32'(m) * 32'(16'hffff - m);
    corr = (32'(mm[31:16]) * 32'(ITOC_LOG_CORR)) >> ITOC_FRAC;
    itoc_log2 = {5'h0, e, 16'h0} + 24'(m) + 24'(corr[15:0]);
  endfunction : itoc_log2

  // ==========================================================================
  // Characteristics stage and decision stage
  // ==========================================================================
  // One shared divider serves all phases in turn; a sample period is far
  // longer than the three times two divisions, so area wins over speed.
  always_comb begin
    itoc_curve_t cv;
    logic        curve_mode;
    logic        active;
    logic [32:0] rem_s;
    logic [23:0] ratio;
    logic [23:0] lg;
    logic [47:0] y;
    logic [47:0] sq;
    logic [31:0] den;
    logic [35:0] q;
    logic [47:0] t_op;
    logic [47:0] t_min;
    logic [47:0] t_rst;
    logic [47:0] el;
    logic [47:0] rel;
    cv         = itoc_curve(4'(operation_mode - ITOC_IEC_INV));
    curve_mode = (operation_mode >= ITOC_IEC_INV) &&
                 (operation_mode <= ITOC_ANSI_LEINV);
    active     = !block && (curve_mode || operation_mode == ITOC_DEFINITE);
    rem_s      = '0;
    ratio      = '0;
    lg         = '0;
    y          = '0;
    sq         = '0;
    den        = '0;
    q          = '0;
    t_op       = '0;
    t_min      = '0;
    t_rst      = '0;
    el         = '0;
    rel        = '0;
    s_next     = s_reg;

    // Restoring divider step shared by both division states.
    if (s_reg.cnt != 6'h0) begin
      rem_s = {s_reg.rem[31:0], s_reg.quo[47]};
      s_next.quo = {s_reg.quo[46:0], 1'b0};
      if (rem_s >= 33'(s_reg.dvs)) begin
        rem_s = rem_s - 33'(s_reg.dvs);
        s_next.quo[0] = 1'b1;
      end
      s_next.rem = rem_s;
      s_next.cnt = s_reg.cnt - 6'h1;
    end

    case (s_reg.fsm)
      ITOC_ST_IDLE: begin
        if (sample_valid && active) begin
          s_next.meas  = phase_fundamental_rms;
          s_next.phase = 2'h0;
          s_next.fsm   = ITOC_ST_RATIO;
          s_next.quo   = {16'h0, phase_fundamental_rms.rms[0], 16'h0};
          s_next.rem   = '0;
          s_next.dvs   = 32'(start_current_setting);
          s_next.cnt   = DIV_N;
        end
      end
      ITOC_ST_RATIO: begin
        if (s_reg.cnt == 6'h0) begin
          s_next.above = s_reg.meas.rms[s_reg.phase] > start_current_setting;
          s_next.fsm   = ITOC_ST_CURVE;
        end
      end
      ITOC_ST_CURVE: begin
        ratio = (s_reg.quo[47:24] != 24'h0 || s_reg.quo[23:0] > ITOC_RATIO_LIM)
                ? ITOC_RATIO_LIM : s_reg.quo[23:0];
        sq = (48'(ratio) * 48'(ratio)) >> ITOC_FRAC;
        if (s_reg.above) begin
          case (cv.alpha)
            ITOC_A002: begin
              lg  = itoc_log2(ratio);
              y   = (48'(lg) * 48'(ITOC_Y_COEF)) >> ITOC_Y_SHIFT;
              den = 32'(y) + 32'((y * y) >> ITOC_SQ_SHIFT);
            end
            ITOC_A1: den = 32'(ratio - ITOC_Q_ONE);
            ITOC_A2: den = 32'(sq) - 32'(ITOC_Q_ONE);
            default: den = '0;
          endcase
          s_next.quo = 48'({cv.k_us, 16'h0});
        end else begin
          den = 32'(ITOC_Q_ONE) - 32'(sq);
          s_next.quo = 48'({cv.kr_us, 16'h0});
        end
        s_next.rem = '0;
        s_next.dvs = den;
        s_next.cnt = DIV_N;
        s_next.fsm = ITOC_ST_TIME;
      end
      ITOC_ST_TIME: begin
        if (s_reg.cnt == 6'h0) begin
          s_next.fsm = ITOC_ST_UPDATE;
        end
      end
      ITOC_ST_UPDATE: begin
        q   = (s_reg.quo[47:36] != 12'h0) ? ITOC_Q_SAT : s_reg.quo[35:0];
        el  = s_reg.elapsed[s_reg.phase];
        rel = s_reg.rst_el[s_reg.phase];
        t_op  = 48'(time_multiplier) * 48'(37'(q) + 37'(cv.c_us));
        t_min = 48'(min_delay_ms) * 48'(ITOC_MS_TO_UNIT);
        if (t_min > t_op) begin
          t_op = t_min;
        end
        if (operation_mode == ITOC_DEFINITE) begin
          t_op = 48'(definite_delay_ms) * 48'(ITOC_MS_TO_UNIT);
        end
        if (s_reg.above) begin
          el  = el + SAMPLE_UNITS;
          rel = '0;
          s_next.start[s_reg.phase] = 1'b1;
          s_next.trip[s_reg.phase]  = el >= t_op;
        end else begin
          s_next.start[s_reg.phase] = 1'b0;
          s_next.trip[s_reg.phase]  = 1'b0;
          t_rst = 48'(time_multiplier) * 48'(q);
          if (!cv.ansi) begin
            t_rst = 48'(reset_delay_ms) * 48'(ITOC_MS_TO_UNIT);
          end
          if (operation_mode == ITOC_DEFINITE) begin
            t_rst = '0;
          end
          if (el != 48'h0) begin
            rel = rel + SAMPLE_UNITS;
          end
          if (rel >= t_rst) begin
            el  = '0;
            rel = '0;
          end
        end
        s_next.elapsed[s_reg.phase] = el;
        s_next.rst_el[s_reg.phase]  = rel;
        if (s_reg.phase == 2'h2) begin
          s_next.fsm = ITOC_ST_IDLE;
        end else begin
          s_next.phase = s_reg.phase + 2'h1;
          s_next.quo   = {16'h0, s_reg.meas.rms[s_reg.phase + 2'h1], 16'h0};
          s_next.rem   = '0;
          s_next.dvs   = 32'(start_current_setting);
          s_next.cnt   = DIV_N;
          s_next.fsm   = ITOC_ST_RATIO;
        end
      end
      default: s_next.fsm = ITOC_ST_IDLE;
    endcase

    if (!active) begin
      s_next.fsm     = ITOC_ST_IDLE;
      s_next.cnt     = '0;
      s_next.elapsed = '0;
      s_next.rst_el  = '0;
      s_next.start   = '0;
      s_next.trip    = '0;
    end
    s_next.gstart = |s_next.start;
    s_next.gtrip  = |s_next.trip;
  end

  // State register; every output is taken straight from it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg     <= '0;
      s_reg.fsm <= ITOC_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register.
  assign phase_start   = s_reg.start;
  assign phase_trip    = s_reg.trip;
  assign general_start = s_reg.gstart;
  assign general_trip  = s_reg.gtrip;

endmodule : itoc_overcurrent

`default_nettype wire

// File: bench/itoc_front_end.sv
// Behavioural measurement front end feeding one sample per request.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Front end model
// ==========================================================================
module itoc_front_end
  import itoc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       fire,
  input  wire itoc_meas_t rms_in,
  output logic            sample_valid,
  output itoc_meas_t      phase_fundamental_rms
);
  itoc_meas_t hold_reg;
  logic [8:0] age_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_valid <= 1'b0;
      hold_reg     <= '0;
      age_reg      <= 9'h1ff;
    end else begin
      sample_valid <= fire;
      if (fire) begin
        hold_reg <= rms_in;
        age_reg  <= 9'h000;
      end else if (age_reg != 9'h1ff) begin
        age_reg <= age_reg + 9'h001;
      end
    end
  end
  // Stale values are inverted so a late read never sees the old sample.
  assign phase_fundamental_rms = (age_reg < 9'h14a) ? hold_reg : ~hold_reg;
endmodule : itoc_front_end
`default_nettype wire

// File: bench/itoc_overcurrent_sva.sv
// Checker of flag combining, clearing and timing of the overcurrent element.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Checker
// ==========================================================================
module itoc_overcurrent_chk
  import itoc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       sample_valid,
  input wire itoc_mode_t operation_mode,
  input wire logic       block,
  input wire logic [2:0] phase_start,
  input wire logic [2:0] phase_trip,
  input wire logic       general_start,
  input wire logic       general_trip
);
  logic [9:0] since_reg;
  // Cycles since the last sample; saturates so long idle spans stay quiet.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) since_reg <= 10'h3ff;
    else if (sample_valid) since_reg <= 10'h000;
    else if (since_reg != 10'h3ff) since_reg <= since_reg + 10'h001;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_gen_start_or: assert property (general_start == |phase_start)
    else $error("general start differs from phase starts");
  a_gen_trip_or: assert property (general_trip == |phase_trip)
    else $error("general trip differs from phase trips");
  a_block_clears: assert property (block |=>
    !general_start && !general_trip)
    else $error("flags survive block");
  a_off_clears: assert property ((operation_mode == ITOC_OFF) |=>
    phase_start == 3'h0 && phase_trip == 3'h0)
    else $error("flags survive off mode");
  a_trip_has_start: assert property (
    (phase_trip & ~phase_start) == 3'h0)
    else $error("trip without start");
  a_trip_timing: assert property ($rose(general_trip) |->
    since_reg inside {[10'h03c:10'h154]})
    else $error("trip rose outside sample processing");
  a_start_timing: assert property ($rose(general_start) |->
    since_reg inside {[10'h03c:10'h154]})
    else $error("start rose outside sample processing");
  a_flags_idle: assert property ((since_reg > 10'h154 && !block &&
    operation_mode != ITOC_OFF) |=>
    $stable(phase_start) && $stable(phase_trip))
    else $error("flags moved while idle");
  c_trip: cover property ($rose(general_trip));
  c_start: cover property ($rose(general_start));
  c_block: cover property (block && general_start);
endmodule : itoc_overcurrent_chk
bind itoc_overcurrent itoc_overcurrent_chk u_chk (.mclk(mclk), .rst(rst),
  .sample_valid(sample_valid), .operation_mode(operation_mode),
  .block(block), .phase_start(phase_start), .phase_trip(phase_trip),
  .general_start(general_start), .general_trip(general_trip));
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench of the overcurrent element.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Testbench
// ==========================================================================
module tb_top
  import itoc_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, fire = 1'b0, block = 1'b0;
  logic        sample_valid, general_start, general_trip;
  logic [2:0]  phase_start, phase_trip;
  logic [15:0] min_delay_ms = 16'h0000, definite_delay_ms = 16'h0005;
  logic [15:0] reset_delay_ms = 16'h0003, start_set = 16'h0064;
  logic [31:0] seed = 32'hc963f702, v;
  itoc_meas_t  rms_in = '0, phase_fundamental_rms;
  itoc_mode_t  operation_mode = ITOC_OFF;
  itoc_mode_t  offm[2] = '{ITOC_OFF, itoc_mode_t'(4'hd)};
  int          miscompares = 0, checks = 0, cycles = 0, n;

  itoc_front_end u_fe (.mclk(mclk), .rst(rst), .fire(fire), .rms_in(rms_in),
    .sample_valid(sample_valid),
    .phase_fundamental_rms(phase_fundamental_rms));
  itoc_overcurrent #(.SAMPLE_US(1000)) u_dut (.mclk(mclk), .rst(rst),
    .sample_valid(sample_valid), .phase_fundamental_rms(phase_fundamental_rms),
    .operation_mode(operation_mode), .start_current_setting(start_set),
    .time_multiplier(11'h005), .min_delay_ms(min_delay_ms),
    .definite_delay_ms(definite_delay_ms), .reset_delay_ms(reset_delay_ms),
    .block(block), .phase_start(phase_start), .phase_trip(phase_trip),
    .general_start(general_start), .general_trip(general_trip));

  // Free-running clock; the timeout guards against a hung design.
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Operate time in ms at TMS 0.05, ratio clamped at twenty.
  function automatic real op_ms(real k, real c, real a, real r, real mind);
    real rr, t;
    rr = (r > 20.0) ? 20.0 : r;
    t = 50.0 * (k / (rr ** a - 1.0) + c);
    return (t > mind) ? t : mind;
  endfunction : op_ms

  task automatic check(string what, logic [5:0] seen, logic [5:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask : check

  // One sample, then wait until all three phases are settled.
  task automatic feed(logic [15:0] a, logic [15:0] b, logic [15:0] c);
    @(posedge mclk);
    #1 rms_in.rms = {c, b, a};
    fire = 1'b1;
    @(posedge mclk);
    #1 fire = 1'b0;
    repeat (348) @(posedge mclk);
    #1;
  endtask : feed

  task automatic until_trip(logic [15:0] a, int max, output int cnt);
    cnt = 0;
    do begin
      feed(a, 16'h0000, 16'h0000);
      cnt++;
    end while (general_trip !== 1'b1 && cnt < max);
  endtask : until_trip

  // Block clears flags and timers; it is used between scenarios.
  task automatic clear();
    @(posedge mclk);
    #1 block = 1'b1;
    repeat (2) @(posedge mclk);
    #1 check("blocked", {phase_start, phase_trip}, 6'h00);
    block = 1'b0;
  endtask : clear

  // Partial run, a spell below start, then the samples left to trip.
  task automatic reset_case(itoc_mode_t m, int nb, logic [15:0] low, int op,
    real tr);
    int na;
    na = op / 3;
    operation_mode = m;
    repeat (na) feed(16'h07d0, 16'h0000, 16'h0000);
    repeat (nb) feed(low, 16'h0000, 16'h0000);
    check("below", {phase_start, phase_trip}, 6'h00);
    until_trip(16'h07d0, op + 2, n);
    check("after_reset", 6'(n),
      6'((nb >= tr) ? op : op - na));
    clear();
  endtask : reset_case

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence of scenarios.
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    foreach (offm[i]) begin
      operation_mode = offm[i];
      feed(16'h0bb8, 16'h0bb8, 16'h0bb8);
      check("off", {phase_start, phase_trip}, 6'h00);
    end
    operation_mode = ITOC_DEFINITE;
    until_trip(16'h012c, 8, n);
    check("definite", 6'(n), 6'h05);
    check("def_flags", {phase_start, phase_trip}, 6'h09);
    check("general", {4'h0, general_start, general_trip}, 6'h03);
    // Switching off with flags standing must clear them at once.
    operation_mode = ITOC_OFF;
    repeat (2) @(posedge mclk);
    #1 check("off_clears", {phase_start, phase_trip}, 6'h00);
    operation_mode = ITOC_DEFINITE;
    clear();
    feed(16'h0064, 16'h0065, 16'h0000);
    check("at_start", {phase_start, phase_trip}, 6'h10);
    clear();
    // At the guaranteed level of 1.1 times start the curve must start.
    operation_mode = ITOC_ANSI_INV;
    feed(16'h006e, 16'h0000, 16'h0000);
    check("guaranteed", {phase_start, phase_trip}, 6'h08);
    clear();
    operation_mode = ITOC_IEC_EINV;
    for (int r = 20; r <= 40; r += 20) begin
      until_trip(16'(r * 100), 14, n);
      check("clamp", 6'(n),
        6'(int'($ceil(op_ms(80, 0, 2, r, 0)))));
      clear();
    end
    // A doubled start level halves the ratio seen by the curve.
    start_set = 16'h00c8;
    until_trip(16'h0bb8, 22, n);
    check("start_scale", 6'(n),
      6'(int'($ceil(op_ms(80, 0, 2, 15, 0)))));
    clear();
    start_set = 16'h0064;
    min_delay_ms = 16'h0014;
    until_trip(16'h07d0, 24, n);
    check("min_delay", 6'(n), 6'(int'(op_ms(80, 0, 2, 20, 20))));
    clear();
    min_delay_ms = 16'h0000;
    for (int nb = 2; nb <= 3; nb++)
      reset_case(ITOC_IEC_EINV, nb, 16'h0000,
        int'($ceil(op_ms(80, 0, 2, 20, 0))), 3.0);
    min_delay_ms = 16'h001e;
    for (int nb = 28; nb <= 33; nb += 5)
      reset_case(ITOC_ANSI_INV, nb, 16'h0032,
        int'($ceil(op_ms(0.0086, 0.0185, 0.02, 20, 30))),
        50.0 * 0.46 / (1.0 - 0.25));
    // Random currents around the start level; no trip within this span.
    operation_mode = ITOC_DEFINITE;
    definite_delay_ms = 16'h003c;
    repeat (12) begin
      v = xs();
      feed(16'(v[7:0]), 16'(v[15:8]), 16'(v[23:16]));
      check("rand", {phase_start, phase_trip}, {v[23:16] > 8'h64,
        v[15:8] > 8'h64, v[7:0] > 8'h64, 3'h0});
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
